// file: stc_term_cal_regs.sv
// register bank for receiver termination calibration of two lane blocks
// ----------------------------------------
// How it works
// - writing trigger bit 0->1 in block two starts its calibration run
// - writing trigger bit 0->1 in block one starts its calibration run
// - override bit 4 clear uses the calibrated code, other bits ignored
// - override bit 4 set forces bits 3..1 as the termination code
// - block one override governs lanes 0, 1, 6 and 7
// - block two override governs lanes 2, 3, 4 and 5
// - block one readback shows calibrated code in bits 3..0, upper zero
// - block two readback shows calibrated code in bits 3..0
// - lane trim is signed magnitude, bit 3 sign, bits 2..0 amount
// - lane 0 trim sits in its own register and only trims lane 0
// - lane 1 trim sits in its own register and only trims lane 1
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
module stc_term_cal_regs (
    // clock and reset of the configuration port
    input wire logic clock,
    input wire logic rst,
    // decoded configuration port access
    input wire logic [stc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [stc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_rd,
    output logic [stc_pkg::DATA_W-1:0] reg_rdata,
    // calibration engine, block one
    output logic grp1_cal_kick,
    input wire logic grp1_cal_done,
    input wire logic [stc_pkg::CODE_W-1:0] grp1_cal_result,
    // calibration engine, block two
    output logic grp2_cal_kick,
    input wire logic grp2_cal_done,
    input wire logic [stc_pkg::CODE_W-1:0] grp2_cal_result,
    // termination code per lane, lane n in bits 4n+3..4n
    output logic [stc_pkg::LANES*stc_pkg::CODE_W-1:0] lane_term
);
    import stc_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic trig1;
        logic trig2;
        logic [DATA_W-1:0] grp1_resistor_override;
        logic [DATA_W-1:0] grp2_resistor_override;
        logic [CODE_W-1:0] rb1;
        logic [CODE_W-1:0] rb2;
        logic [CODE_W-1:0] trim0;
        logic [CODE_W-1:0] trim1;
        logic kick1;
        logic kick2;
        logic [DATA_W-1:0] rdata;
        logic [LANES*CODE_W-1:0] term;
    } stc_state_t;

    localparam stc_state_t STATE_RST = '{
        trig1: 1'b0,
        trig2: 1'b0,
        grp1_resistor_override: RST_BYTE,
        grp2_resistor_override: RST_BYTE,
        rb1: RST_CODE,
        rb2: RST_CODE,
        trim0: RST_CODE,
        trim1: RST_CODE,
        kick1: 1'b0,
        kick2: 1'b0,
        rdata: RST_BYTE,
        term: '0
    };

    stc_state_t st_r;
    stc_state_t st_nxt;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // override decode, used for both blocks
    function automatic logic [CODE_W-1:0] block_code(
        input logic [DATA_W-1:0] ovr,
        input logic [CODE_W-1:0] cal
    );
        logic [CODE_W-1:0] forced;
        forced = {1'b0, ovr[OVR_CODE_LSB +: FORCE_W]};
        block_code = ovr[OVR_EN_BIT] ? forced : cal;
    endfunction

    function automatic logic [DATA_W-1:0] pad_code(input logic [CODE_W-1:0] c);
        pad_code = {{(DATA_W-CODE_W){1'b0}}, c};
    endfunction

    // ----------------------------------------
    // block codes and lane trims
    // ----------------------------------------
    logic [CODE_W-1:0] blk1_code;
    logic [CODE_W-1:0] blk2_code;
    logic [LANES*CODE_W-1:0] term_calc;
    logic wr_trig1;
    logic wr_trig2;

    assign blk1_code = block_code(st_r.grp1_resistor_override, st_r.rb1);
    assign blk2_code = block_code(st_r.grp2_resistor_override, st_r.rb2);

    // only lanes 0 and 1 carry trim registers, the rest take the plain block code
    stc_trim_if trim_bus [TRIM_LANES] ();

    genvar gi;
    generate
        for (gi = 0; gi < LANES; gi++) begin : g_lane
            if (gi < TRIM_LANES) begin : g_trim
                assign trim_bus[gi].base = BLK1_LANES[gi] ? blk1_code : blk2_code;
                assign trim_bus[gi].trim = (gi == 0) ? st_r.trim0 : st_r.trim1;
                stc_lane_trim u_trim (
                    .t(trim_bus[gi])
                );
                assign term_calc[gi*CODE_W +: CODE_W] = trim_bus[gi].result;
            end else begin : g_plain
                assign term_calc[gi*CODE_W +: CODE_W] =
                    BLK1_LANES[gi] ? blk1_code : blk2_code;
            end
        end
    endgenerate

    assign wr_trig1 = reg_wr && (reg_addr == OFS_BLK1_TRIGGER);
    assign wr_trig2 = reg_wr && (reg_addr == OFS_BLK2_TRIGGER);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.kick1 = 1'b0;
        st_nxt.kick2 = 1'b0;
        // lane codes registered so the analog side never sees decode glitches
        st_nxt.term = term_calc;
        if (wr_trig1) begin
            st_nxt.trig1 = reg_wdata[TRIG_BIT];
            st_nxt.kick1 = reg_wdata[TRIG_BIT] && !st_r.trig1;
        end
        if (wr_trig2) begin
            st_nxt.trig2 = reg_wdata[TRIG_BIT];
            st_nxt.kick2 = reg_wdata[TRIG_BIT] && !st_r.trig2;
        end
        if (reg_wr) begin
            unique case (reg_addr)
                OFS_BLK1_OVERRIDE: st_nxt.grp1_resistor_override = reg_wdata;
                OFS_BLK2_OVERRIDE: st_nxt.grp2_resistor_override = reg_wdata;
                OFS_LANE0_TRIM: st_nxt.trim0 = reg_wdata[CODE_W-1:0];
                OFS_LANE1_TRIM: st_nxt.trim1 = reg_wdata[CODE_W-1:0];
                default: ;
            endcase
        end
        // readback follows the engine, writes to it are dropped
        if (grp1_cal_done) begin
            st_nxt.rb1 = grp1_cal_result;
        end
        if (grp2_cal_done) begin
            st_nxt.rb2 = grp2_cal_result;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_BLK1_TRIGGER: st_nxt.rdata = pad_code({3'h0, st_r.trig1});
                OFS_BLK1_OVERRIDE: st_nxt.rdata = st_r.grp1_resistor_override;
                OFS_BLK1_READBACK: st_nxt.rdata = pad_code(st_r.rb1);
                OFS_BLK2_TRIGGER: st_nxt.rdata = pad_code({3'h0, st_r.trig2});
                OFS_BLK2_OVERRIDE: st_nxt.rdata = st_r.grp2_resistor_override;
                OFS_BLK2_READBACK: st_nxt.rdata = pad_code(st_r.rb2);
                OFS_LANE0_TRIM: st_nxt.rdata = pad_code(st_r.trim0);
                OFS_LANE1_TRIM: st_nxt.rdata = pad_code(st_r.trim1);
                default: st_nxt.rdata = RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r <= STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reg_rdata = st_r.rdata;
    assign grp1_cal_kick = st_r.kick1;
    assign grp2_cal_kick = st_r.kick2;
    assign lane_term = st_r.term;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_rise2;
        wr_trig2 && reg_wdata[TRIG_BIT] && !st_r.trig2;
    endsequence

    sequence s_rise1;
        wr_trig1 && reg_wdata[TRIG_BIT] && !st_r.trig1;
    endsequence

    chk_blk2_kick_edge: assert property (@(posedge clock) disable iff (rst)
        s_rise2 |=> grp2_cal_kick ##1 !grp2_cal_kick)
        else $error("block two kick missing or too long");

    chk_blk1_kick_edge: assert property (@(posedge clock) disable iff (rst)
        s_rise1 |=> grp1_cal_kick ##1 !grp1_cal_kick)
        else $error("block one kick missing or too long");

    chk_kick_cause: assert property (@(posedge clock) disable iff (rst)
        grp2_cal_kick |-> $past(wr_trig2) && $past(reg_wdata[TRIG_BIT]) && !$past(st_r.trig2))
        else $error("block two kick without a write");

    chk_blk1_auto_code: assert property (@(posedge clock) disable iff (rst)
        !st_r.grp1_resistor_override[OVR_EN_BIT] && !grp1_cal_done && !reg_wr
        |=> lane_term[7*CODE_W +: CODE_W] == st_r.rb1)
        else $error("lane 7 does not follow calibrated code");

    chk_blk2_forced: assert property (@(posedge clock) disable iff (rst)
        st_r.grp2_resistor_override[OVR_EN_BIT] && !reg_wr
        |=> lane_term[3*CODE_W +: CODE_W] ==
            {1'b0, $past(st_r.grp2_resistor_override[OVR_CODE_LSB +: FORCE_W])})
        else $error("lane 3 does not take the forced code");

    chk_blk2_lanes: assert property (@(posedge clock) disable iff (rst)
        !reg_wr |=> lane_term[5*CODE_W +: CODE_W] == lane_term[2*CODE_W +: CODE_W])
        else $error("block two lanes disagree");

    chk_readback_zero: assert property (@(posedge clock) disable iff (rst)
        reg_rd && reg_addr == OFS_BLK1_READBACK
        |=> reg_rdata == pad_code($past(st_r.rb1)))
        else $error("block one readback wrong");

    chk_trim_clamp: assert property (@(posedge clock) disable iff (rst)
        !st_r.trim0[TRIM_SIGN_BIT] && st_r.trim0[TRIM_MAG_W-1:0] != 3'h0
        && blk1_code == CODE_MAX |=> lane_term[CODE_W-1:0] == CODE_MAX)
        else $error("lane 0 trim wrapped");

    chk_lane1_trim: assert property (@(posedge clock) disable iff (rst)
        st_r.trim1[TRIM_SIGN_BIT] && blk1_code < {1'b0, st_r.trim1[TRIM_MAG_W-1:0]}
        |=> lane_term[CODE_W +: CODE_W] == CODE_MIN)
        else $error("lane 1 subtract did not saturate");

    // ----------------------------------------
    // kick, capture and lane routing checks
    // ----------------------------------------
    chk_blk1_kick_cause: assert property (@(posedge clock) disable iff (rst)
        grp1_cal_kick |-> $past(wr_trig1) && $past(reg_wdata[TRIG_BIT]) && !$past(st_r.trig1))
        else $error("block one kick without a write");

    // a repeated 1 must not start a second run
    chk_blk1_no_rekick: assert property (@(posedge clock) disable iff (rst)
        wr_trig1 && st_r.trig1 |=> !grp1_cal_kick)
        else $error("block one kicked with trigger already set");

    chk_blk2_no_rekick: assert property (@(posedge clock) disable iff (rst)
        wr_trig2 && st_r.trig2 |=> !grp2_cal_kick)
        else $error("block two kicked with trigger already set");

    chk_rb1_capture: assert property (@(posedge clock) disable iff (rst)
        grp1_cal_done |=> st_r.rb1 == $past(grp1_cal_result))
        else $error("block one result not captured");

    chk_rb2_capture: assert property (@(posedge clock) disable iff (rst)
        grp2_cal_done |=> st_r.rb2 == $past(grp2_cal_result))
        else $error("block two result not captured");

    chk_blk2_readback: assert property (@(posedge clock) disable iff (rst)
        reg_rd && reg_addr == OFS_BLK2_READBACK
        |=> reg_rdata == pad_code($past(st_r.rb2)))
        else $error("block two readback wrong");

    // auto mode must ignore the forced code bits
    chk_blk2_auto_code: assert property (@(posedge clock) disable iff (rst)
        !st_r.grp2_resistor_override[OVR_EN_BIT] && !grp2_cal_done && !reg_wr
        |=> lane_term[2*CODE_W +: CODE_W] == st_r.rb2)
        else $error("lane 2 does not follow calibrated code");

    // lanes 6 and 7 stay on block one, untrimmed
    chk_blk1_lanes: assert property (@(posedge clock) disable iff (rst)
        1'b1 |=> lane_term[6*CODE_W +: CODE_W] == $past(blk1_code)
            && lane_term[7*CODE_W +: CODE_W] == $past(blk1_code))
        else $error("lanes 6 and 7 left block one");

    // a zero trim leaves lane 0 on the plain block code
    chk_lane0_zero_trim: assert property (@(posedge clock) disable iff (rst)
        st_r.trim0[TRIM_MAG_W-1:0] == 3'h0 |=> lane_term[CODE_W-1:0] == $past(blk1_code))
        else $error("lane 0 moved by a zero trim");

    chk_lane1_zero_trim: assert property (@(posedge clock) disable iff (rst)
        st_r.trim1[TRIM_MAG_W-1:0] == 3'h0 |=> lane_term[CODE_W +: CODE_W] == $past(blk1_code))
        else $error("lane 1 moved by a zero trim");
endmodule // stc_term_cal_regs
`default_nettype wire

// file: stc_pkg.sv
// constants for the termination calibration register bank
package stc_pkg;
    // ----------------------------------------
    // bus widths
    // ----------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int CODE_W = 4;
    localparam int FORCE_W = 3;
    localparam int LANES = 8;
    localparam int TRIM_LANES = 2;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] OFS_BLK1_TRIGGER = 12'h2a7;
    localparam logic [ADDR_W-1:0] OFS_BLK1_OVERRIDE = 12'h2a8;
    localparam logic [ADDR_W-1:0] OFS_BLK1_READBACK = 12'h2ac;
    localparam logic [ADDR_W-1:0] OFS_BLK2_TRIGGER = 12'h2ae;
    localparam logic [ADDR_W-1:0] OFS_BLK2_OVERRIDE = 12'h2af;
    localparam logic [ADDR_W-1:0] OFS_BLK2_READBACK = 12'h2b3;
    localparam logic [ADDR_W-1:0] OFS_LANE0_TRIM = 12'h2bb;
    localparam logic [ADDR_W-1:0] OFS_LANE1_TRIM = 12'h2bc;

    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int TRIG_BIT = 0;
    localparam int OVR_EN_BIT = 4;
    localparam int OVR_CODE_LSB = 1;
    localparam int TRIM_SIGN_BIT = 3;
    localparam int TRIM_MAG_W = 3;
    localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
    localparam logic [CODE_W-1:0] RST_CODE = 4'h0;
    localparam logic [CODE_W-1:0] CODE_MAX = 4'hf;
    localparam logic [CODE_W-1:0] CODE_MIN = 4'h0;
    // lanes served by the first block, one bit per lane
    localparam logic [LANES-1:0] BLK1_LANES = 8'hc3;
endpackage

// file: stc_trim_if.sv
// carrier between the bank and a lane trim calculator
`timescale 1ns/1ps
`default_nettype none
interface stc_trim_if;
    import stc_pkg::*;
    logic [CODE_W-1:0] base;
    logic [CODE_W-1:0] trim;
    logic [CODE_W-1:0] result;
    modport bank (output base, output trim, input result);
    modport calc (input base, input trim, output result);
endinterface
`default_nettype wire

// file: stc_lane_trim.sv
// signed-magnitude trim of one lane's termination code, clamped
`timescale 1ns/1ps
`default_nettype none
module stc_lane_trim (
    // trim values in, trimmed code out
    stc_trim_if.calc t
);
    import stc_pkg::*;

    logic [CODE_W:0] sum;
    logic [CODE_W-1:0] mag;

    always_comb begin
        mag = {1'b0, t.trim[TRIM_MAG_W-1:0]};
        sum = {1'b0, t.base} + {1'b0, mag};
        if (t.trim[TRIM_SIGN_BIT]) begin
            t.result = (mag > t.base) ? CODE_MIN : t.base - mag;
        end else begin
            t.result = sum[CODE_W] ? CODE_MAX : sum[CODE_W-1:0];
        end
    end
endmodule // stc_lane_trim
`default_nettype wire

// file: tb_serdes_termination_cal_ctrl.sv
// self-checking testbench for the termination calibration register bank
`timescale 1ns/1ps
`default_nettype none
module tb_serdes_termination_cal_ctrl;
    import stc_pkg::*;
    logic clock, rst, reg_wr, reg_rd, grp1_cal_done, grp2_cal_done;
    logic grp1_cal_kick, grp2_cal_kick, tg1, tg2;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, rdv, ovr1, ovr2, tr0, tr1;
    logic [CODE_W-1:0] grp1_cal_result, grp2_cal_result, rb1, rb2;
    logic [LANES*CODE_W-1:0] lane_term;
    logic [31:0] lfsr;
    logic [ADDR_W-1:0] amap [0:8];
    int fails, cmp_count;

    stc_term_cal_regs dut_u (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .grp1_cal_kick(grp1_cal_kick), .grp1_cal_done(grp1_cal_done),
        .grp1_cal_result(grp1_cal_result), .grp2_cal_kick(grp2_cal_kick),
        .grp2_cal_done(grp2_cal_done), .grp2_cal_result(grp2_cal_result),
        .lane_term(lane_term));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ----------------------------------------
    // expectation functions
    // ----------------------------------------
    function automatic logic [31:0] rnd(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // saturate instead of wrapping, a wrap would flip termination strength
    function automatic logic [CODE_W-1:0] trim_code(logic [CODE_W-1:0] c, logic [DATA_W-1:0] t);
        int v;
        v = t[3] ? int'(c) - int'(t[2:0]) : int'(c) + int'(t[2:0]);
        if (v < 0) v = 0;
        if (v > 15) v = 15;
        return v[CODE_W-1:0];
    endfunction

    function automatic logic [31:0] exp_lanes();
        logic [CODE_W-1:0] c1, c2, c;
        logic [31:0] r;
        c1 = ovr1[4] ? {1'b0, ovr1[3:1]} : rb1;
        c2 = ovr2[4] ? {1'b0, ovr2[3:1]} : rb2;
        r = '0;
        for (int i = 0; i < LANES; i++) begin
            c = BLK1_LANES[i] ? c1 : c2;
            if (i == 0) c = trim_code(c, tr0);
            if (i == 1) c = trim_code(c, tr1);
            r[i*4 +: 4] = c;
        end
        return r;
    endfunction

    function automatic logic [7:0] exp_reg(logic [ADDR_W-1:0] a);
        case (a)
            OFS_BLK1_TRIGGER: return {7'h00, tg1};
            OFS_BLK2_TRIGGER: return {7'h00, tg2};
            OFS_BLK1_OVERRIDE: return ovr1;
            OFS_BLK2_OVERRIDE: return ovr2;
            OFS_BLK1_READBACK: return {4'h0, rb1};
            OFS_BLK2_READBACK: return {4'h0, rb2};
            OFS_LANE0_TRIM: return tr0;
            OFS_LANE1_TRIM: return tr1;
            default: return 8'h00;
        endcase
    endfunction

    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clock);
        #1;
        reg_rd = 1'b0;
        rdv = reg_rdata;
        check(rdv, exp_reg(a), "read data");
        // idle edge, so a following read never re-raises the strobe in this step
        @(posedge clock);
        #1;
    endtask

    task automatic chk_lanes();
        repeat (3) @(posedge clock);
        #1;
        check(lane_term, exp_lanes(), "lane codes");
    endtask

    task automatic cal(input logic g, input logic [CODE_W-1:0] r);
        grp1_cal_done = !g;
        grp2_cal_done = g;
        grp1_cal_result = r;
        grp2_cal_result = ~r;
        @(posedge clock);
        #1;
        grp1_cal_done = 1'b0;
        grp2_cal_done = 1'b0;
        if (g) rb2 = ~r;
        else rb1 = r;
        rd(g ? OFS_BLK2_READBACK : OFS_BLK1_READBACK);
        chk_lanes();
    endtask

    task automatic wr_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic k1, k2;
        k1 = (a == OFS_BLK1_TRIGGER) && d[0] && !tg1;
        k2 = (a == OFS_BLK2_TRIGGER) && d[0] && !tg2;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clock);
        #1;
        reg_wr = 1'b0;
        check(grp1_cal_kick, k1, "kick one");
        check(grp2_cal_kick, k2, "kick two");
        case (a)
            OFS_BLK1_TRIGGER: tg1 = d[0];
            OFS_BLK2_TRIGGER: tg2 = d[0];
            OFS_BLK1_OVERRIDE: ovr1 = d;
            OFS_BLK2_OVERRIDE: ovr2 = d;
            OFS_LANE0_TRIM: tr0 = {4'h0, d[3:0]};
            OFS_LANE1_TRIM: tr1 = {4'h0, d[3:0]};
            default: ;
        endcase
        @(posedge clock);
        #1;
        check({grp1_cal_kick, grp2_cal_kick}, 2'b00, "kick width");
        rd(a);
        chk_lanes();
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        amap = '{OFS_BLK1_TRIGGER, OFS_BLK1_OVERRIDE, OFS_BLK1_READBACK, OFS_BLK2_TRIGGER,
            OFS_BLK2_OVERRIDE, OFS_BLK2_READBACK, OFS_LANE0_TRIM, OFS_LANE1_TRIM, 12'h123};
        {reg_wr, reg_rd, grp1_cal_done, grp2_cal_done, tg1, tg2} = '0;
        {reg_addr, reg_wdata, grp1_cal_result, grp2_cal_result} = '0;
        {ovr1, ovr2, tr0, tr1, rb1, rb2} = '0;
        fails = 0;
        cmp_count = 0;
        lfsr = 32'h5fdaf3bd;
        rst = 1'b1;
        repeat (5) @(posedge clock);
        #1;
        rst = 1'b0;
        for (int i = 0; i < 9; i++) rd(amap[i]);
        chk_lanes();
        $display("test reset values finished");
        // second kick only after the bit went low again
        for (int g = 0; g < 2; g++) begin
            wr_chk(g ? OFS_BLK2_TRIGGER : OFS_BLK1_TRIGGER, 8'h01);
            wr_chk(g ? OFS_BLK2_TRIGGER : OFS_BLK1_TRIGGER, 8'h01);
            wr_chk(g ? OFS_BLK2_TRIGGER : OFS_BLK1_TRIGGER, 8'h00);
            wr_chk(g ? OFS_BLK2_TRIGGER : OFS_BLK1_TRIGGER, 8'hff);
        end
        $display("test triggers finished");
        for (int g = 0; g < 2; g++) begin
            cal(g[0], 4'ha);
            for (int c = 0; c < 8; c++) begin
                lfsr = rnd(lfsr);
                wr_chk(g ? OFS_BLK2_OVERRIDE : OFS_BLK1_OVERRIDE,
                    {lfsr[7:5], 1'b1, c[2:0], lfsr[0]});
            end
            wr_chk(g ? OFS_BLK2_OVERRIDE : OFS_BLK1_OVERRIDE, {lfsr[7:5], 1'b0, lfsr[3:0]});
        end
        $display("test override codes finished");
        // both ends of the code range, add and subtract
        wr_chk(OFS_LANE0_TRIM, 8'h07);
        wr_chk(OFS_LANE1_TRIM, 8'h0f);
        cal(1'b0, 4'hf);
        cal(1'b0, 4'h2);
        wr_chk(OFS_LANE0_TRIM, 8'hff);
        cal(1'b0, 4'h0);
        $display("test trim clamp finished");
        for (int n = 0; n < 150; n++) begin
            lfsr = rnd(lfsr);
            if (lfsr[3:0] < 4'h3) cal(lfsr[4], lfsr[8:5]);
            else wr_chk(amap[lfsr[31:16] % 9], lfsr[15:8]);
        end
        $display("test random traffic finished");
        // reset in mid-run must clear every register and output again
        rst = 1'b1;
        @(posedge clock);
        #1;
        check({grp1_cal_kick, grp2_cal_kick, reg_rdata}, 10'h000, "outputs in reset");
        check(lane_term, 32'h0, "lanes in reset");
        rst = 1'b0;
        {tg1, tg2, ovr1, ovr2, tr0, tr1, rb1, rb2} = '0;
        for (int i = 0; i < 9; i++) rd(amap[i]);
        chk_lanes();
        $display("test mid-run reset finished");
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        complete_run();
    end
endmodule // tb_serdes_termination_cal_ctrl
`default_nettype wire
